// >>> shared/bias_sel_defs.svh
`ifndef BIAS_SEL_DEFS_SVH
`define BIAS_SEL_DEFS_SVH
// ------------------------------------------------------------
// constants for the bias output selection block
// ------------------------------------------------------------
`define NUM_OUT 4
`define NUM_DAC 8
`define DAC_CODE_W 13
`define PAGE_W 8
`define REG_ADDR_W 8
// reset values
`define RST_CLAMP_SEL 4'h0
`define RST_DRIVE_EN 8'h00
`define RST_POWER_EN 8'h00
`define RST_DRV_SRC 4'h1
`define RST_PAGE 8'h00
`define RST_CODE 13'h0000
// page on which the bias channel code buffers live
`define CODE_PAGE 8'h01
// drive-enable source select bit positions
`define SRC_SW 0
`define SRC_PIN0 1
`define SRC_PIN1 2
`define SRC_FLEX 3
`endif

// >>> shared/bias_sel_pkg.sv
package bias_sel_pkg;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // what a switched output carries
  typedef enum logic [1:0] {
    SRC_RAIL = 2'h0,
    SRC_ODD = 2'h1,
    SRC_EVEN = 2'h2
  } out_src_t;
  // register write request from the host-side serial front end
  typedef struct packed {
    logic valid;
    logic [7:0] page;
    logic [7:0] addr;
    logic [12:0] data;
  } reg_wr_t;
  // one entry per switched output
  typedef struct packed {
    out_src_t src;
  } out_route_t;
  // drive-enable source selection
  typedef enum logic [3:0] {
    DRV_SW = 4'h1,
    DRV_PIN0 = 4'h2,
    DRV_PIN1 = 4'h4,
    DRV_FLEX = 4'h8
  } drv_src_t;
endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// two-stage synchroniser for a bus of pin levels
// ------------------------------------------------------------
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic sysClk,
  input wire logic rstn,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta; // first stage, read only by syncOut

  // first stage feeds only the second stage
  always_ff @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      syncOut <= '0;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule

// >>> rtl/bias_output_select_logic.sv
`timescale 1ns/100ps
`include "bias_sel_defs.svh"
// Operation
// R1: after reset outputs sit on negative rail
// R2: clamp bit 0 rail, 1 odd DAC
// R3: even drive enable overrides clamp path
// R4: even channel powers on with power enable
// R5: odd channel needs power and drive enable
// R6: reset selects software drive-enable source
// R7: software may pick one hardware source
// R8: each channel has writable code buffer
// R9: registers paged; host sets page first
// R10: selection combinational, drive enable has priority; code registers the routed outputs on sys_clk
module bias_output_select_logic
  import bias_sel_pkg::*;
#(
  parameter int CODE_W = `DAC_CODE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // software control bits (same clock domain)
  input wire logic [3:0] output_clamp_select,
  input wire logic [7:0] dac_drive_enable_bit,
  input wire logic [7:0] dac_power_enable,
  input wire logic [3:0] driveSourceSelect,
  // host register writes, already decoded from serial
  input wire reg_wr_t regWrite,
  // hardware pins, asynchronous
  input wire logic drive_enable_pin_zero,
  input wire logic drive_enable_pin_one,
  input wire logic flexible_io_pin,
  // output routing, one entry per switched output
  output out_route_t switched_output_a_first,
  output out_route_t switched_output_a_second,
  output out_route_t switched_output_b_first,
  output out_route_t switched_output_b_second,
  // per-channel power state and effective drive enables
  output logic [7:0] dacPowered,
  output logic [7:0] effDriveEnable,
  // code buffers, channel index a0..a3 then b0..b3
  output logic [`NUM_DAC*CODE_W-1:0] dac_code_buffer,
  // current page
  output logic [7:0] currentPage
);
  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  logic [2:0] pinSync; // {flex, pin1, pin0} after two flops

  pin_sync #(.WIDTH(3)) pin_sync_i (
    .sysClk(sys_clk),
    .rstn(rstn),
    .asyncIn({flexible_io_pin, drive_enable_pin_one,
      drive_enable_pin_zero}),
    .syncOut(pinSync)
  );

  // ------------------------------------------------------------
  // drive-enable source selection
  // ------------------------------------------------------------
  drv_src_t drvSrc; // registered source choice
  drv_src_t next_drvSrc;
  logic hwLevel; // selected hardware pin level
  logic [7:0] next_eff;

  // only a one-hot request is accepted; anything else keeps the
  // old choice so a half-written selection cannot glitch drives
  always_comb begin
    case (driveSourceSelect)
      4'h1: next_drvSrc = DRV_SW;
      4'h2: next_drvSrc = DRV_PIN0; // R7
      4'h4: next_drvSrc = DRV_PIN1; // R7
      4'h8: next_drvSrc = DRV_FLEX; // R7
      default: next_drvSrc = drvSrc;
    endcase
  end

  // hardware level picked by the chosen source
  assign hwLevel = (drvSrc == DRV_PIN0) ? pinSync[0] :
    (drvSrc == DRV_PIN1) ? pinSync[1] :
    (drvSrc == DRV_FLEX) ? pinSync[2] : 1'b0;

  // a hardware source gates every channel's software bit
  assign next_eff = (drvSrc == DRV_SW) ? dac_drive_enable_bit :
    (dac_drive_enable_bit & {8{hwLevel}});

  // source register, software after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      drvSrc <= drv_src_t'(`RST_DRV_SRC); // R6
    end else begin
      drvSrc <= next_drvSrc;
    end
  end

  // ------------------------------------------------------------
  // output routing
  // ------------------------------------------------------------
  // pick source for output k from its even/odd channel pair
  function automatic out_src_t route(input logic clampBit,
    input logic evenDrive);
    if (evenDrive) begin
      route = SRC_EVEN; // R3 R10
    end else if (clampBit) begin
      route = SRC_ODD; // R2
    end else begin
      route = SRC_RAIL; // R2
    end
  endfunction

  // even channels are 0 and 2 in each group of four
  out_src_t next_route [4];
  assign next_route[0] = route(output_clamp_select[0], next_eff[0]);
  assign next_route[1] = route(output_clamp_select[1], next_eff[2]);
  assign next_route[2] = route(output_clamp_select[2], next_eff[4]);
  assign next_route[3] = route(output_clamp_select[3], next_eff[6]);

  // power qualification: odd channels need their drive enable
  logic [7:0] next_power;
  assign next_power = dac_power_enable &
    (next_eff | 8'h55); // R4 R5

  // outputs are flopped from a single combinational decision, so no
  // partial state is ever held between the two selection stages
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      switched_output_a_first <= '{src: SRC_RAIL}; // R1
      switched_output_a_second <= '{src: SRC_RAIL}; // R1
      switched_output_b_first <= '{src: SRC_RAIL}; // R1
      switched_output_b_second <= '{src: SRC_RAIL}; // R1
      dacPowered <= `RST_POWER_EN;
      effDriveEnable <= `RST_DRIVE_EN;
    end else begin
      switched_output_a_first <= '{src: next_route[0]}; // R10
      switched_output_a_second <= '{src: next_route[1]};
      switched_output_b_first <= '{src: next_route[2]};
      switched_output_b_second <= '{src: next_route[3]};
      dacPowered <= next_power;
      effDriveEnable <= next_eff;
    end
  end

  // ------------------------------------------------------------
  // paged code buffers
  // ------------------------------------------------------------
  logic [CODE_W-1:0] codeMem [`NUM_DAC]; // one word per channel
  logic pageWrite; // write hits the page register
  logic codeWrite; // write hits a code buffer on current page

  // page register answers on every page at address 0xFF
  assign pageWrite = regWrite.valid && (regWrite.addr == 8'hFF);
  // a buffer write only lands if the host set the page first
  assign codeWrite = regWrite.valid && !pageWrite &&
    (currentPage == `CODE_PAGE) && (regWrite.addr < 8'h08); // R9

  // page register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      currentPage <= `RST_PAGE;
    end else if (pageWrite) begin
      currentPage <= regWrite.data[7:0]; // R9
    end
  end

  // channel code buffers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NUM_DAC; i++) begin
        codeMem[i] <= CODE_W'(`RST_CODE);
      end
    end else if (codeWrite) begin
      codeMem[regWrite.addr[2:0]] <= regWrite.data[CODE_W-1:0]; // R8
    end
  end

  // buffers out as a flat vector, straight from flops
  always_comb begin
    for (int i = 0; i < `NUM_DAC; i++) begin
      dac_code_buffer[i*CODE_W +: CODE_W] = codeMem[i];
    end
  end
endmodule

// >>> testbench/bias_output_select_logic_chk.sv
`timescale 1ns/100ps
`include "bias_sel_defs.svh"
module bias_output_select_logic_chk
  import bias_sel_pkg::*;
#(
  parameter int CODE_W = `DAC_CODE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // controls
  input wire logic [3:0] output_clamp_select,
  input wire logic [7:0] dac_drive_enable_bit,
  input wire logic [7:0] dac_power_enable,
  input wire reg_wr_t regWrite,
  // results
  input wire out_route_t switched_output_a_first,
  input wire out_route_t switched_output_a_second,
  input wire out_route_t switched_output_b_first,
  input wire logic [7:0] dacPowered,
  input wire logic [7:0] effDriveEnable,
  input wire logic [`NUM_DAC*CODE_W-1:0] dac_code_buffer,
  input wire logic [7:0] currentPage
);
  // all checks on the one system clock
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_even_wins: assert property (
    effDriveEnable[0] |-> switched_output_a_first.src == SRC_EVEN)
    else $error("even route lost");
  a_clamp_path: assert property (
    !effDriveEnable[2] |-> switched_output_a_second.src ==
    ($past(output_clamp_select[1]) ? SRC_ODD : SRC_RAIL))
    else $error("clamp route wrong");
  a_drive_priority: assert property (
    !effDriveEnable[4] |-> switched_output_b_first.src != SRC_EVEN)
    else $error("even route without drive");
  a_even_power: assert property (
    dacPowered[4] == $past(dac_power_enable[4])) else $error("even power");
  a_odd_power: assert property (
    dacPowered[5] == ($past(dac_power_enable[5]) && effDriveEnable[5]))
    else $error("odd power");
  a_drive_gated: assert property (
    (effDriveEnable & ~$past(dac_drive_enable_bit)) == 8'h00)
    else $error("drive without software bit");
  a_page_hold: assert property (
    !$past(regWrite.valid) |-> $stable(currentPage)) else $error("page moved");
  a_code_refuse: assert property (
    ($past(currentPage) != `CODE_PAGE || !$past(regWrite.valid))
    |-> $stable(dac_code_buffer)) else $error("code changed");
endmodule
bind bias_output_select_logic bias_output_select_logic_chk #(
  .CODE_W(CODE_W)) bias_output_select_logic_chk_i (.sys_clk(sys_clk),
  .rstn(rstn), .output_clamp_select(output_clamp_select),
  .dac_drive_enable_bit(dac_drive_enable_bit),
  .dac_power_enable(dac_power_enable), .regWrite(regWrite),
  .switched_output_a_first(switched_output_a_first),
  .switched_output_a_second(switched_output_a_second),
  .switched_output_b_first(switched_output_b_first),
  .dacPowered(dacPowered), .effDriveEnable(effDriveEnable),
  .dac_code_buffer(dac_code_buffer), .currentPage(currentPage));

// >>> testbench/bias_output_select_logic_tb.sv
`timescale 1ns/100ps
module bias_output_select_logic_tb;
  import bias_sel_pkg::*;
  logic sysClk = 0, rstn = 0;
  logic [3:0] clamp = 0, srcSel = 4'h1;
  logic [7:0] drv = 0, pwr = 0, eff, powered, page, pg = 0;
  logic [2:0] pins = 0; // pin zero, pin one, flexible pin
  reg_wr_t regWrite = '0;
  out_route_t r0, r1, r2, r3;
  logic [103:0] buffer;
  logic [12:0] code [8];
  logic [31:0] seed = 32'hF41D350A, qs[$];
  logic [15:0] qc[$]; // channel and expected code
  int failures = 0, checks = 0, cycles = 0;
  always #25 sysClk = ~sysClk;
  bias_output_select_logic bias_output_select_logic_i (.sys_clk(sysClk),
    .rstn(rstn), .output_clamp_select(clamp), .dac_drive_enable_bit(drv),
    .dac_power_enable(pwr), .driveSourceSelect(srcSel), .regWrite(regWrite),
    .drive_enable_pin_zero(pins[0]), .drive_enable_pin_one(pins[1]),
    .flexible_io_pin(pins[2]), .switched_output_a_first(r0),
    .switched_output_a_second(r1), .switched_output_b_first(r2),
    .switched_output_b_second(r3), .dacPowered(powered),
    .effDriveEnable(eff), .dac_code_buffer(buffer), .currentPage(page));
  function void nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  // expected outputs from the enables actually in force
  function automatic logic [31:0] model(logic [7:0] e);
    logic [7:0] r;
    for (int k = 0; k < 4; k++)
      r[2*k+:2] = e[2*k] ? SRC_EVEN : (clamp[k] ? SRC_ODD : SRC_RAIL);
    return {r, pwr & (e | 8'h55), e, pg};
  endfunction
  task automatic step(int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [12:0] d);
    @(negedge sysClk);
    regWrite = '{1'b1, 8'h00, a, d};
  endtask
  task automatic cmpCtl(logic [31:0] e);
    logic [31:0] s;
    s = {r3, r2, r1, r0, powered, eff, page};
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] outputs exp %h got %h", e, s);
    end
  endtask
  task automatic cmpCode(logic [15:0] e);
    logic [12:0] s;
    s = buffer[e[15:13]*13+:13];
    checks++;
    if (s !== e[12:0]) begin
      failures++;
      $display("[FAIL] code %0d exp %h got %h", e[15:13], e[12:0], s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watcher: compares settled outputs with the oldest notes
  always @(negedge sysClk) begin
    while (qs.size() > 0) cmpCtl(qs.pop_front());
    while (qc.size() > 0) cmpCode(qc.pop_front());
  end
  // cycle ceiling, far above the roughly 140 cycles the tests need
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge sysClk);
    @(negedge sysClk) rstn = 1;
    step(2);
    qs.push_back(model(8'h00));
    // random controls, pins toggling under software source
    repeat (40) begin
      @(negedge sysClk);
      nxt();
      {pins, pwr, drv, clamp} = seed[22:0];
      step(2);
      qs.push_back(model(drv));
    end
    // each hardware source: only its own pin gates the drive
    for (int s = 0; s < 3; s++) begin
      @(negedge sysClk);
      {drv, srcSel, pins} = {8'hFF, 4'h2 << s, 3'h1 << s};
      step(4);
      qs.push_back(model(8'hFF));
      @(negedge sysClk) pins = ~pins;
      step(4);
      qs.push_back(model(8'h00));
    end
    // a malformed select keeps the flexible pin source
    @(negedge sysClk) {srcSel, pins} = {4'h6, 3'h4};
    step(4);
    qs.push_back(model(8'hFF));
    // back to software: pins no longer gate the drive bits
    @(negedge sysClk) {srcSel, pins, drv} = {4'h1, 3'h0, 8'h5A};
    step(4);
    qs.push_back(model(8'h5A));
    wr(8'h02, 13'h1ABC); // refused while on page zero
    step(2);
    qc.push_back({3'h2, 13'h0000});
    wr(8'hFF, 13'h0001);
    pg = 8'h01;
    for (int i = 0; i < 8; i++) begin
      nxt();
      code[i] = seed[12:0];
      wr(8'(i), code[i]); // back to back
    end
    wr(8'h08, 13'h1FFF); // no such channel
    @(negedge sysClk) regWrite.valid = 1'b0;
    step(2);
    qs.push_back(model(drv));
    for (int i = 0; i < 8; i++) qc.push_back({3'(i), code[i]});
    step(2);
    finish_test();
  end
endmodule
